// >>> sldrv_regs.svh
// Summary of operation
// RULE1 - Eight-stage shift register feeds eight-bit storage
// RULE2 - Shift clock rise shifts serial data in
// RULE3 - Latch clock rise copies shift into storage
// RULE4 - Low clear forces all shift stages zero
// RULE5 - Clear high: storage passes to output buffer
// RULE6 - Enable high holds all buffer bits low
// RULE7 - Enable low: buffer follows storage bits
// RULE8 - Serial output carries shift data for chaining
// RULE9 - Buffer bit high sinks, low switches off
// RULE10 - Serial output is last stage, after edges
// RULE11 - Host shifts whole chain, then latches once
`ifndef SLDRV_REGS_SVH
`define SLDRV_REGS_SVH

`define SLD_WIDTH        8
`define SLD_SHIFT_RST    8'h00
`define SLD_STORE_RST    8'h00
`define SLD_BUF_OFF      8'h00
`define SLD_SYNC_STAGES  3
`define SLD_PIN_RST_LOW  1'b0
`define SLD_PIN_RST_HIGH 1'b1
`define SLD_PAD_LOW      1'b0
`define SLD_SETTLE_BITS  4
`define SLD_SETTLE_ZERO  4'h0
`define SLD_SETTLE_STEP  4'h1
`define SLD_FAULT_SETTLE 4'h8

`endif

// >>> sldrv_pkg.sv
`include "sldrv_regs.svh"
package sldrv_pkg;
    // One byte of driver data
    typedef logic [`SLD_WIDTH-1:0] sldrv_word_t;
    // Three stage pin sampler
    typedef logic [`SLD_SYNC_STAGES-1:0] sldrv_sync_t;
endpackage : sldrv_pkg

// >>> sldrv_shift_if.sv
`timescale 1ns/1ns
`default_nettype none
// Carries the link-side shift state to the core-side logic
interface sldrv_shift_if;
    sldrv_pkg::sldrv_word_t shift_word;
    logic                   cascade_bit;
    modport shifter (output shift_word, output cascade_bit);
    modport core    (input shift_word, input cascade_bit);
endinterface : sldrv_shift_if
`default_nettype wire

// >>> sldrv_shift.sv
`timescale 1ns/1ns
`default_nettype none
`include "sldrv_regs.svh"
module sldrv_shift (
    input  wire logic       shift_clock_in,
    input  wire logic       reset,
    input  wire logic       shift_clear_n,
    input  wire logic       serial_data_in,
    sldrv_shift_if.shifter  link
);
    sldrv_pkg::sldrv_word_t shift_q;
    sldrv_pkg::sldrv_word_t shift_d;

    // Clear acts without any shift edge, since the host may stop the clock
    logic clear_any;
    assign clear_any = reset | ~shift_clear_n;

    // New bit enters stage zero, oldest bit moves toward the top
    assign shift_d = {shift_q[`SLD_WIDTH-2:0], serial_data_in}; // RULE2

    // Eight stages on the link clock
    always_ff @(posedge shift_clock_in or posedge clear_any)
    begin
        if (clear_any)
            shift_q <= `SLD_SHIFT_RST; // RULE4
        else
            shift_q <= shift_d; // RULE1 RULE2
    end

    // Parallel word and chain bit straight from the stages
    assign link.shift_word  = shift_q;
    assign link.cascade_bit = shift_q[`SLD_WIDTH-1]; // RULE8 RULE10
endmodule : sldrv_shift
`default_nettype wire

// >>> sldrv_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sldrv_regs.svh"
module sldrv_top #(
    parameter int WIDTH = `SLD_WIDTH
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             shift_clock_in,
    input  wire logic             serial_data_in,
    input  wire logic             shift_clear_n,
    input  wire logic             latch_clock_in,
    input  wire logic             output_enable_n,
    output logic                  cascade_serial_out,
    input  wire logic [WIDTH-1:0] drain_in,
    output logic      [WIDTH-1:0] drain_out,
    output logic      [WIDTH-1:0] drain_oe_n,
    output logic      [WIDTH-1:0] drain_fault
);
    sldrv_shift_if link_if ();

    sldrv_pkg::sldrv_sync_t latch_sync_q;
    sldrv_pkg::sldrv_sync_t enable_sync_q;
    sldrv_pkg::sldrv_sync_t drain_sync_q [WIDTH];
    logic                   latch_level_q;
    logic                   enable_n_level_q;
    logic                   latch_rise;
    logic                   latch_pend_q;
    logic                   word_quiet;
    logic                   capture;
    sldrv_pkg::sldrv_word_t word_sync1_q;
    sldrv_pkg::sldrv_word_t word_sync2_q;
    sldrv_pkg::sldrv_word_t word_sync3_q;
    sldrv_pkg::sldrv_word_t drain_level_q;
    logic [`SLD_SETTLE_BITS-1:0] settle_q [WIDTH];
    sldrv_pkg::sldrv_word_t store_q;
    sldrv_pkg::sldrv_word_t store_d;
    sldrv_pkg::sldrv_word_t buf_q;
    sldrv_pkg::sldrv_word_t buf_d;
    sldrv_pkg::sldrv_word_t fault_q;

    // Shift stages live on the link's own clock
    sldrv_shift u_shift (
        .shift_clock_in (shift_clock_in),
        .reset          (reset),
        .shift_clear_n  (shift_clear_n),
        .serial_data_in (serial_data_in),
        .link           (link_if.shifter)
    );

    // Chain bit leaves straight from the last link-side stage
    assign cascade_serial_out = link_if.cascade_bit; // RULE8 RULE10

    // Latch pin sampler; idle low so no false capture follows reset
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            latch_sync_q <= '0;
        else
            latch_sync_q <= {latch_sync_q[1:0], latch_clock_in};
    end

    // Enable pin sampler; idle high keeps the sinks off out of reset
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            enable_sync_q <= '1;
        else
            enable_sync_q <= {enable_sync_q[1:0], output_enable_n};
    end

    // A level only counts once stages two and three agree
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            latch_level_q <= `SLD_PIN_RST_LOW;
        else if (latch_sync_q[1] == latch_sync_q[2])
            latch_level_q <= latch_sync_q[2];
    end

    // Same agreement for enable, so a short glitch never reaches the sinks
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            enable_n_level_q <= `SLD_PIN_RST_HIGH;
        else if (enable_sync_q[1] == enable_sync_q[2])
            enable_n_level_q <= enable_sync_q[2];
    end

    // Agreed latch level going high is one capture
    assign latch_rise = (latch_sync_q[1] == latch_sync_q[2]) & latch_sync_q[2] & ~latch_level_q;

    // Shift word crosses by two flops per bit; the host keeps it still
    // while latching, and the quiet check below rejects a torn word
    generate
        for (genvar i = 0; i < WIDTH; i++)
        begin : g_word_sync
            always_ff @(posedge core_clk or posedge reset)
            begin
                if (reset)
                begin
                    word_sync1_q[i] <= `SLD_PAD_LOW;
                    word_sync2_q[i] <= `SLD_PAD_LOW;
                end
                else
                begin
                    word_sync1_q[i] <= link_if.shift_word[i];
                    word_sync2_q[i] <= word_sync1_q[i];
                end
            end

            // One more sample of the settled bit, for the quiet check
            always_ff @(posedge core_clk or posedge reset)
            begin
                if (reset)
                    word_sync3_q[i] <= `SLD_PAD_LOW;
                else
                    word_sync3_q[i] <= word_sync2_q[i];
            end
        end
    endgenerate

    // Word counts as settled once two successive samples match, so a
    // bit caught mid-change is never stored beside its neighbours
    assign word_quiet = (word_sync2_q == word_sync3_q);

    // A latch landing while the word still moves waits for it; a host
    // that never stops shifting holds the capture off
    assign capture = (latch_rise | latch_pend_q) & word_quiet; // RULE3

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            latch_pend_q <= `SLD_PIN_RST_LOW;
        else
            latch_pend_q <= (latch_rise | latch_pend_q) & ~word_quiet;
    end

    // Storage keeps its byte until the next capture
    assign store_d = capture ? word_sync3_q : store_q; // RULE3

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            store_q <= `SLD_STORE_RST;
        else
            store_q <= store_d; // RULE1 RULE3
    end

    // Clearing the shift stages never disturbs storage or buffer
    // Disabled buffer is all zero, enabled buffer mirrors storage
    assign buf_d = enable_n_level_q ? `SLD_BUF_OFF : store_q; // RULE5 RULE6 RULE7

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            buf_q <= `SLD_BUF_OFF;
        else
            buf_q <= buf_d; // RULE6 RULE7
    end

    // Open drain sinks: only ever pull low, enable low while sinking
    generate
        for (genvar j = 0; j < WIDTH; j++)
        begin : g_drain
            assign drain_out[j]  = `SLD_PAD_LOW;
            assign drain_oe_n[j] = ~buf_q[j]; // RULE9
        end
    endgenerate

    // Flags a sinking pin whose wire still reads high; drain wires are pad
    // levels, so each passes three flops like the control pins
    generate
        for (genvar k = 0; k < WIDTH; k++)
        begin : g_fault
            // Pad sampler; idle high since the load pulls the wire up
            always_ff @(posedge core_clk or posedge reset)
            begin
                if (reset)
                    drain_sync_q[k] <= '1;
                else
                    drain_sync_q[k] <= {drain_sync_q[k][1:0], drain_in[k]};
            end

            // Wire level once stages two and three agree
            always_ff @(posedge core_clk or posedge reset)
            begin
                if (reset)
                    drain_level_q[k] <= `SLD_PIN_RST_HIGH;
                else if (drain_sync_q[k][1] == drain_sync_q[k][2])
                    drain_level_q[k] <= drain_sync_q[k][2];
            end

            // Cycles since the sink switched on; the wire needs its fall
            // time plus the sampler delay before a high means anything
            always_ff @(posedge core_clk or posedge reset)
            begin
                if (reset)
                    settle_q[k] <= `SLD_SETTLE_ZERO;
                else if (!buf_q[k])
                    settle_q[k] <= `SLD_SETTLE_ZERO;
                else if (settle_q[k] != `SLD_FAULT_SETTLE)
                    settle_q[k] <= settle_q[k] + `SLD_SETTLE_STEP;
            end

            // Sinking, settled and still high: load or wire is open
            always_ff @(posedge core_clk or posedge reset)
            begin
                if (reset)
                    fault_q[k] <= `SLD_PAD_LOW;
                else
                    fault_q[k] <= buf_q[k] & drain_level_q[k]
                                  & (settle_q[k] == `SLD_FAULT_SETTLE);
            end
        end
    endgenerate

    assign drain_fault = fault_q;
endmodule : sldrv_top
`default_nettype wire

// >>> sldrv_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sldrv_top_sva #(
    parameter int WIDTH = 8
) (
    input wire logic             core_clk,
    input wire logic             reset,
    input wire logic             shift_clock_in,
    input wire logic             serial_data_in,
    input wire logic             shift_clear_n,
    input wire logic             latch_clock_in,
    input wire logic             output_enable_n,
    input wire logic             cascade_serial_out,
    input wire logic [WIDTH-1:0] drain_in,
    input wire logic [WIDTH-1:0] drain_out,
    input wire logic [WIDTH-1:0] drain_oe_n,
    input wire logic [WIDTH-1:0] drain_fault
);
    // Core domain by default; the link check names its own edge
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_out; drain_out == '0; endproperty
    a_out: assert property (p_out) else $error("drain_out driven");
    property p_off; output_enable_n[*8] |-> &drain_oe_n; endproperty
    a_off: assert property (p_off) else $error("sink on while off");
    property p_rise; $rose(output_enable_n) |-> ##[1:6] &drain_oe_n; endproperty
    a_rise: assert property (p_rise) else $error("slow turn off");
    property p_hold; (!latch_clock_in && !output_enable_n)[*8] |-> $stable(drain_oe_n); endproperty
    a_hold: assert property (p_hold) else $error("sink moved");
    property p_lat; $rose(latch_clock_in) && $stable(output_enable_n) |=> $stable(drain_oe_n)[*2];
    endproperty
    a_lat: assert property (p_lat) else $error("early latch");
    property p_keep; $fell(shift_clear_n) |=> $stable(drain_oe_n)[*4]; endproperty
    a_keep: assert property (p_keep) else $error("clear hit outputs");
    property p_clr; !shift_clear_n |-> !cascade_serial_out; endproperty
    a_clr: assert property (p_clr) else $error("cascade not cleared");
    // Link edges since the last clear, saturating at eight
    logic [3:0] link_cnt_q;
    always_ff @(posedge shift_clock_in or posedge reset or negedge shift_clear_n)
    begin
        if (reset || !shift_clear_n)
            link_cnt_q <= 4'h0;
        else if (link_cnt_q != 4'h8)
            link_cnt_q <= link_cnt_q + 4'h1;
    end
    // Eight stages: a bit reaches the cascade pin eight link edges on
    property p_casc;
        @(posedge shift_clock_in) link_cnt_q == 4'h8
            |-> cascade_serial_out == $past(serial_data_in, 8);
    endproperty
    a_casc: assert property (p_casc) else $error("cascade order");
    c_lat: cover property ($rose(latch_clock_in));
    c_on: cover property (!(&drain_oe_n));
    c_clr: cover property ($fell(shift_clear_n));
endmodule : sldrv_top_sva
bind sldrv_top sldrv_top_sva #(.WIDTH(WIDTH)) i_sldrv_top_sva (.*);
`default_nettype wire

// >>> sldrv_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sldrv_host_model (
    output logic shift_clock_in,
    output logic serial_data_in,
    output logic latch_clock_in
);
    // Link clock stands low between frames
    initial
    begin
        shift_clock_in = 1'b0;
        serial_data_in = 1'b0;
        latch_clock_in = 1'b0;
    end
    // Msb first at 30 ns, data moved on the falling edge, 15 ns ahead of the rise for setup and hold
    task automatic send(input logic [7:0] w);
        #7;
        for (int i = 7; i >= 0; i--)
        begin
            serial_data_in = w[i];
            #15 shift_clock_in = 1'b1;
            #15 shift_clock_in = 1'b0;
        end
        serial_data_in = ~w[0]; // Stale line shown inverted
    endtask : send
    // Quiet gap before the pulse lets the word settle
    task automatic latch();
        #41 latch_clock_in = 1'b1;
        #40 latch_clock_in = 1'b0;
    endtask : latch
endmodule : sldrv_host_model
`default_nettype wire

// >>> sldrv_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sldrv_top_bench;
    logic                   core_clk, reset, shift_clear_n, output_enable_n;
    logic                   shift_clock_in, serial_data_in, latch_clock_in, cascade_serial_out;
    sldrv_pkg::sldrv_word_t drain_in, drain_out, drain_oe_n, drain_fault;
    sldrv_pkg::sldrv_word_t stuck_q;
    int                     bad_count = 0;
    int                     num_checks = 0;
    int                     cycles = 0;
    sldrv_top i_sldrv_top (.*);
    sldrv_host_model i_sldrv_host_model (.*);
    // Pulled-up drains read low only while sunk, unless a wire is held high
    assign drain_in = drain_oe_n | stuck_q;
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic cmp_word(input string n, input sldrv_pkg::sldrv_word_t e, s);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : cmp_word
    task automatic cmp_bit(input string n, input logic e, s);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", n, e, s);
        end
    endtask : cmp_bit
    task automatic settle();
        repeat (8) @(negedge core_clk);
    endtask : settle
    task automatic load_word();
        @(posedge core_clk) output_enable_n <= 1'b0;
        settle();
        cmp_word("sinks", 8'hff, drain_oe_n);
        i_sldrv_host_model.send(8'ha5);
        cmp_bit("cascade", 1'b1, cascade_serial_out);
        i_sldrv_host_model.latch();
        settle();
        cmp_word("sinks", 8'h5a, drain_oe_n);
        cmp_word("fault", 8'h00, drain_fault);
    endtask : load_word
    task automatic chain_word();
        i_sldrv_host_model.send(8'h3c);
        cmp_bit("cascade", 1'b0, cascade_serial_out);
        cmp_word("sinks", 8'h5a, drain_oe_n);
        i_sldrv_host_model.latch();
        settle();
        cmp_word("sinks", 8'hc3, drain_oe_n);
    endtask : chain_word
    task automatic enable_off();
        @(posedge core_clk) output_enable_n <= 1'b1;
        settle();
        cmp_word("sinks", 8'hff, drain_oe_n);
        @(posedge core_clk) output_enable_n <= 1'b0;
        settle();
        cmp_word("sinks", 8'hc3, drain_oe_n);
    endtask : enable_off
    task automatic stuck_drain();
        @(posedge core_clk) stuck_q <= 8'h05;
        settle();
        cmp_word("fault", 8'h04, drain_fault);
        @(posedge core_clk) stuck_q <= 8'h00;
        settle();
        cmp_word("fault", 8'h00, drain_fault);
    endtask : stuck_drain
    task automatic clear_shift();
        i_sldrv_host_model.send(8'h81);
        cmp_bit("cascade", 1'b1, cascade_serial_out);
        @(posedge core_clk) shift_clear_n <= 1'b0;
        settle();
        cmp_bit("cascade", 1'b0, cascade_serial_out);
        cmp_word("sinks", 8'hc3, drain_oe_n);
        @(posedge core_clk) shift_clear_n <= 1'b1;
        i_sldrv_host_model.latch();
        settle();
        cmp_word("sinks", 8'hff, drain_oe_n);
    endtask : clear_shift
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    // Run is a few hundred cycles; the ceiling is generous
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    initial
    begin
        reset = 1'b1;
        shift_clear_n = 1'b1;
        output_enable_n = 1'b1;
        stuck_q = 8'h00;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        load_word();
        chain_word();
        enable_off();
        stuck_drain();
        clear_shift();
        report_and_stop();
    end
endmodule : sldrv_top_bench
`default_nettype wire
